/* rtl/stwrs_device.sv */
// Contract
// R1: first byte: address bits 7:1, direction bit 0
// R2: select low answers 0x90 write, 0x91 read
// R3: select high answers 0xBA write, 0xBB read
// R4: transmitter releases data during acknowledge period
// R5: receiver acknowledges by pulling data low
// R6: master no-acknowledge ends read; device releases
// R7: acknowledge only matching address, else stay silent
// R8: two address bytes, high first, load pointer
// R9: acknowledge, store write byte, increment pointer
// R10: master ends write with stop or restart
// R11: random read: dummy write, restart, read
// R12: read bytes driven msb first, master acknowledges
// R13: pointer increments after every read byte
// R14: current read starts from retained pointer
// R15: sequential transfers acknowledged until count reached
// R16: stop is data rising while clock high
// R17: data changes only while clock low
// R18: master ends every write with stop; the host ends the dummy write of a random read with a restart instead
// R19: start is data falling while clock high
// R20: only sixteen-bit register addressing supported
// R21: serial clock at most pixel clock / 22
// R22: synchronised sampling; start or stop resets sequence
`timescale 1ns/1ps
`default_nettype none
module stwrs_device
  import stwrs_pkg::*;
#(
  parameter int MEM_AW = MEM_AW_DEF // address bits of the byte store
) (
  input wire logic pixel_clock, // link-side clock
  input wire logic mclk, // user-side clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic address_select_input, // address pair select pin
  stwrs_link_if.dev link, // two-wire bus
  output wire logic wr_valid, // one mclk pulse per stored byte
  output wire logic [15:0] wr_addr, // address of the stored byte
  output wire logic [7:0] wr_data // value of the stored byte
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (MEM_AW < 1 || MEM_AW > 16) begin : g_bad_aw
    $error("MEM_AW must lie in 1..16");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic sel_m;
    logic sel_s;
    stwrs_phase_type phase;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [15:0] ptr;
    logic mack;
    logic oe;
    logic zero;
    logic wr_tgl;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
  } stwrs_dev_type;

  typedef struct packed {
    logic tgl_m;
    logic tgl_s;
    logic tgl_p;
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } stwrs_user_type;

  stwrs_dev_type s;
  stwrs_dev_type next_s;
  stwrs_user_type u;
  stwrs_user_type next_u;
  logic [7:0] mem [0:(1 << MEM_AW) - 1];
  logic mem_we;
  logic rise;
  logic fall;
  logic start_seen;
  logic stop_seen;
  logic [6:0] my_addr;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // bus event detection on synchronised lines
  // ----------------------------------------------------------------
  // edges and conditions only look at the second and third flops
  assign rise = s.scl_s & ~s.scl_p; // R22
  assign fall = ~s.scl_s & s.scl_p; // R22
  assign start_seen = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s; // R19
  assign stop_seen = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s; // R16
  // read address byte is the write byte with bit 0 set
  assign my_addr = s.sel_s ? DEV_WR_HI[7:1] : DEV_WR_LO[7:1]; // R2 R3
  assign rd_byte = mem[s.ptr[MEM_AW-1:0]];

  // ----------------------------------------------------------------
  // link-side sequencer
  // ----------------------------------------------------------------
  // data drive changes on a clock fall, so it moves while clock is low; a start or stop also releases it
  always_comb
  begin
    next_s = s;
    mem_we = 1'b0;
    next_s.scl_m = link.scl;
    next_s.scl_s = s.scl_m;
    next_s.scl_p = s.scl_s;
    next_s.sda_m = link.sda;
    next_s.sda_s = s.sda_m;
    next_s.sda_p = s.sda_s;
    next_s.sel_m = address_select_input;
    next_s.sel_s = s.sel_m;
    if (start_seen)
    begin
      // a start or restart always opens a fresh address byte
      next_s.phase = PH_DEV; // R22
      next_s.bitn = 4'h0;
      next_s.oe = 1'b0;
    end
    else if (stop_seen)
    begin
      next_s.phase = PH_IDLE; // R22
      next_s.bitn = 4'h0;
      next_s.oe = 1'b0;
    end
    else if (rise && s.phase != PH_IDLE && s.phase != PH_IGN)
    begin
      if (s.bitn < ACK_SLOT)
      begin
        next_s.bitn = s.bitn + 4'h1;
        if (s.phase != PH_RD)
        begin
          next_s.sh = {s.sh[6:0], s.sda_s}; // R1
        end
      end
      else if (s.bitn == ACK_SLOT)
      begin
        next_s.bitn = ACK_DONE;
        if (s.phase == PH_RD)
        begin
          next_s.mack = s.sda_s; // R5
          next_s.ptr = s.ptr + 16'h0001; // R13
        end
      end
    end
    else if (fall)
    begin
      unique case (s.phase)
        PH_IDLE, PH_IGN:
        begin
          next_s.oe = 1'b0; // R7
        end
        PH_RD:
        begin
          if (s.bitn != 4'h0 && s.bitn < ACK_SLOT)
          begin
            // shift out the next bit, msb first
            next_s.tx = {s.tx[6:0], 1'b0}; // R12
            next_s.oe = ~s.tx[6]; // R12
          end
          else if (s.bitn == ACK_SLOT)
          begin
            next_s.oe = 1'b0; // R4
          end
          else if (s.bitn == ACK_DONE)
          begin
            next_s.bitn = 4'h0;
            if (!s.mack)
            begin
              next_s.tx = rd_byte; // R15
              next_s.oe = ~rd_byte[7]; // R12
            end
            else
            begin
              next_s.phase = PH_IGN; // R6
              next_s.oe = 1'b0; // R6
            end
          end
        end
        PH_DEV, PH_AHI, PH_ALO, PH_WR:
        begin
          if (s.bitn == ACK_SLOT)
          begin
            next_s.oe = 1'b1; // R5
            unique case (s.phase)
              PH_DEV:
              begin
                if (s.sh[7:1] != my_addr)
                begin
                  next_s.phase = PH_IGN; // R7
                  next_s.oe = 1'b0; // R7
                end
              end
              PH_AHI:
              begin
                next_s.ptr[15:8] = s.sh; // R8
              end
              PH_ALO:
              begin
                next_s.ptr[7:0] = s.sh; // R8 R20
              end
              PH_WR:
              begin
                mem_we = 1'b1; // R9
                next_s.ptr = s.ptr + 16'h0001; // R9
                next_s.wr_addr = s.ptr;
                next_s.wr_data = s.sh;
                next_s.wr_tgl = ~s.wr_tgl;
              end
              default:
              begin
                next_s.oe = 1'b0;
              end
            endcase
          end
          else if (s.bitn == ACK_DONE)
          begin
            // acknowledge slot over: release and open the next byte
            next_s.oe = 1'b0; // R4
            next_s.bitn = 4'h0;
            unique case (s.phase)
              PH_DEV:
              begin
                if (s.sh[BIT_RW])
                begin
                  // read: start from the retained pointer
                  next_s.phase = PH_RD; // R14 R11
                  next_s.tx = rd_byte;
                  next_s.oe = ~rd_byte[7]; // R12
                end
                else
                begin
                  next_s.phase = PH_AHI; // R8
                end
              end
              PH_AHI:
              begin
                next_s.phase = PH_ALO; // R8
              end
              default:
              begin
                next_s.phase = PH_WR; // R9
              end
            endcase
          end
        end
        default:
        begin
          next_s.phase = PH_IDLE;
          next_s.oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link-side registers and byte store
  // ----------------------------------------------------------------
  always_ff @(posedge pixel_clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // store written bytes at the pointer
  always_ff @(posedge pixel_clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < (1 << MEM_AW); i++)
      begin
        mem[i] <= 8'h00;
      end
    end
    else if (mem_we)
    begin
      mem[s.ptr[MEM_AW-1:0]] <= s.sh; // R9
    end
  end

  // ----------------------------------------------------------------
  // write report into the user domain
  // ----------------------------------------------------------------
  // toggle crossing; address and data stay still for many bus bits
  always_comb
  begin
    next_u = u;
    next_u.tgl_m = s.wr_tgl;
    next_u.tgl_s = u.tgl_m;
    next_u.tgl_p = u.tgl_s;
    next_u.valid = u.tgl_s ^ u.tgl_p;
    if (u.tgl_s ^ u.tgl_p)
    begin
      next_u.addr = s.wr_addr;
      next_u.data = s.wr_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      u <= '0;
    end
    else
    begin
      u <= next_u;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.sda_out_d = s.zero;
  assign link.sda_oe_d = s.oe; // R17
  assign wr_valid = u.valid;
  assign wr_addr = u.addr;
  assign wr_data = u.data;

endmodule : stwrs_device
`default_nettype wire

/* rtl/stwrs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module stwrs_host
  import stwrs_pkg::*;
#(
  parameter int QDIV = QDIV_DEF // mclk cycles per quarter serial period
) (
  input wire logic mclk, // host clock
  input wire logic nrst, // asynchronous reset, active low
  stwrs_link_if.host link, // two-wire bus
  input wire logic cmd_valid, // command request
  output wire logic cmd_ready, // idle, command accepted when valid
  input wire logic [1:0] cmd_kind, // write, random read, current read
  input wire logic cmd_sel, // device address pair select
  input wire logic [15:0] cmd_addr, // register address
  input wire logic [7:0] cmd_len, // byte count, 0 taken as 1
  input wire logic [7:0] wdata, // write byte, read when take is high
  output wire logic wdata_take, // one-cycle pulse, wdata consumed
  output wire logic rd_valid, // one-cycle pulse per read byte
  output wire logic [7:0] rd_data, // read byte
  output wire logic done, // one-cycle pulse after stop
  output wire logic nack_err // last command saw no-acknowledge
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (QDIV < 1 || QDIV > 255) begin : g_bad_qdiv
    $error("QDIV must lie in 1..255");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    stwrs_hstate_type st;
    stwrs_stage_type stage;
    logic [7:0] div;
    logic [1:0] q;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [7:0] cnt;
    logic [1:0] kind;
    logic [6:0] dev;
    logic [15:0] addr;
    logic sda_m;
    logic sda_s;
    logic scl_low;
    logic sda_low;
    logic zero;
    logic ready;
    logic take;
    logic rvalid;
    logic [7:0] rdata;
    logic done;
    logic nack;
  } stwrs_host_type;

  stwrs_host_type s;
  stwrs_host_type n;
  logic tick;
  logic slot_end;

  assign tick = s.div == 8'(QDIV - 1); // R21
  assign slot_end = tick && s.q == 2'h3;

  // ----------------------------------------------------------------
  // bit-slot sequencer
  // ----------------------------------------------------------------
  // each bit slot: quarters 0,1 clock low, quarters 2,3 clock high; start and stop slots: clock low in quarter 0 only
  always_comb
  begin
    n = s;
    n.sda_m = link.sda;
    n.sda_s = s.sda_m;
    n.take = 1'b0;
    n.rvalid = 1'b0;
    n.done = 1'b0;
    if (s.take)
    begin
      n.sh = wdata;
    end
    if (s.st != H_IDLE)
    begin
      n.div = tick ? 8'h00 : s.div + 8'h01;
      n.q = tick ? s.q + 2'h1 : s.q;
    end
    if (s.st == H_IDLE)
    begin
      if (cmd_valid)
      begin
        n.kind = cmd_kind;
        n.addr = cmd_addr;
        n.cnt = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
        n.dev = cmd_sel ? DEV_WR_HI[7:1] : DEV_WR_LO[7:1];
        n.stage = (cmd_kind == KIND_CUR_READ) ? G_DEVR : G_DEVW;
        n.st = H_START;
        n.nack = 1'b0;
        n.div = 8'h00;
        n.q = 2'h0;
      end
    end
    else if (slot_end)
    begin
      unique case (s.st)
        H_START:
        begin
          n.st = H_TXBIT;
          n.bitn = 3'h0;
          n.sh = {s.dev, s.stage == G_DEVR}; // R1
        end
        H_TXBIT:
        begin
          n.bitn = s.bitn + 3'h1;
          n.sh = {s.sh[6:0], 1'b0};
          n.st = (s.bitn == 3'h7) ? H_TXACK : H_TXBIT;
        end
        H_TXACK:
        begin
          if (s.sda_s)
          begin
            n.nack = 1'b1; // R7
            n.st = H_STOP;
          end
          else
          begin
            n.st = H_TXBIT;
            n.bitn = 3'h0;
            unique case (s.stage)
              G_DEVW:
              begin
                n.stage = G_AHI;
                n.sh = s.addr[15:8]; // R8 R20
              end
              G_AHI:
              begin
                n.stage = G_ALO;
                n.sh = s.addr[7:0];
              end
              G_ALO:
              begin
                if (s.kind == KIND_WRITE)
                begin
                  n.stage = G_WDATA;
                  n.take = 1'b1;
                end
                else
                begin
                  n.stage = G_DEVR;
                  n.st = H_START; // R11
                end
              end
              G_WDATA:
              begin
                n.cnt = s.cnt - 8'h01;
                n.take = s.cnt != 8'h01;
                n.st = (s.cnt == 8'h01) ? H_STOP : H_TXBIT; // R10 R18
              end
              default:
              begin
                n.st = H_RXBIT;
              end
            endcase
          end
        end
        H_RXBIT:
        begin
          n.sh = {s.sh[6:0], s.sda_s};
          n.bitn = s.bitn + 3'h1;
          if (s.bitn == 3'h7)
          begin
            n.st = H_RXACK;
            n.rvalid = 1'b1;
            n.rdata = {s.sh[6:0], s.sda_s};
          end
        end
        H_RXACK:
        begin
          n.cnt = s.cnt - 8'h01;
          n.bitn = 3'h0;
          n.st = (s.cnt == 8'h01) ? H_STOP : H_RXBIT;
        end
        H_STOP:
        begin
          n.st = H_IDLE;
          n.done = 1'b1;
        end
        default:
        begin
          n.st = H_IDLE;
        end
      endcase
    end
    // line drive from the slot about to run
    unique case (n.st)
      H_IDLE:
      begin
        n.scl_low = 1'b0;
        n.sda_low = 1'b0;
      end
      H_START:
      begin
        n.scl_low = n.q == 2'h0;
        n.sda_low = n.q[1]; // R19
      end
      H_STOP:
      begin
        n.scl_low = n.q == 2'h0;
        n.sda_low = ~n.q[1]; // R16
      end
      H_TXBIT:
      begin
        n.scl_low = ~n.q[1];
        n.sda_low = ~n.sh[7]; // R12
      end
      H_RXACK:
      begin
        n.scl_low = ~n.q[1];
        n.sda_low = n.cnt != 8'h01; // R5 R6 R15
      end
      default:
      begin
        n.scl_low = ~n.q[1];
        n.sda_low = 1'b0;
      end
    endcase
    n.ready = n.st == H_IDLE;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.scl_out = s.zero;
  assign link.scl_oe = s.scl_low;
  assign link.sda_out_h = s.zero;
  assign link.sda_oe_h = s.sda_low;
  assign cmd_ready = s.ready;
  assign wdata_take = s.take;
  assign rd_valid = s.rvalid;
  assign rd_data = s.rdata;
  assign done = s.done;
  assign nack_err = s.nack;

endmodule : stwrs_host
`default_nettype wire

/* rtl/stwrs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface stwrs_link_if;
  logic scl_out; // host clock drive value
  logic scl_oe; // host pulls clock line
  logic sda_out_h; // host data drive value
  logic sda_oe_h; // host drives data line
  logic sda_out_d; // device data drive value
  logic sda_oe_d; // device drives data line
  wire scl; // resolved clock line, pulled up
  wire sda; // resolved data line, pulled up

  // open-drain resolution with pull-ups
  assign scl = ~(scl_oe & ~scl_out);
  assign sda = ~((sda_oe_h & ~sda_out_h) | (sda_oe_d & ~sda_out_d));

  modport host (output scl_out, scl_oe, sda_out_h, sda_oe_h, input scl, sda);
  modport dev (output sda_out_d, sda_oe_d, input scl, sda);
endinterface : stwrs_link_if
`default_nettype wire

/* rtl/stwrs_pkg.sv */
package stwrs_pkg;

  // ----------------------------------------------------------------
  // device address bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV_WR_LO = 8'h90; // write byte, select low
  localparam logic [7:0] DEV_RD_LO = 8'h91; // read byte, select low
  localparam logic [7:0] DEV_WR_HI = 8'hBA; // write byte, select high
  localparam logic [7:0] DEV_RD_HI = 8'hBB; // read byte, select high
  localparam int BIT_RW = 0; // direction flag position, 1 = read
  localparam logic [3:0] ACK_SLOT = 4'h8; // bit count at the acknowledge slot
  localparam logic [3:0] ACK_DONE = 4'h9; // acknowledge slot sampled

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 50; // host clock period
  localparam int PIXEL_PERIOD_NS = 30; // device pixel clock period
  localparam int SCL_PIXEL_DIV = 22; // serial clock at most pixel clock / 22
  // mclk cycles per quarter of a serial clock period, rounded up
  localparam int QDIV_DEF = (SCL_PIXEL_DIV * PIXEL_PERIOD_NS + 4 * MCLK_PERIOD_NS - 1)
                            / (4 * MCLK_PERIOD_NS);
  localparam int MEM_AW_DEF = 8; // address bits of the device byte store

  // ----------------------------------------------------------------
  // host commands
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_WRITE = 2'h0; // write bytes at an address
  localparam logic [1:0] KIND_RAND_READ = 2'h1; // dummy write, restart, read
  localparam logic [1:0] KIND_CUR_READ = 2'h2; // read at current pointer

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_DEV = 3'h1,
    PH_AHI = 3'h2,
    PH_ALO = 3'h3,
    PH_WR = 3'h4,
    PH_RD = 3'h5,
    PH_IGN = 3'h6
  } stwrs_phase_type;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_START = 3'h1,
    H_TXBIT = 3'h2,
    H_TXACK = 3'h3,
    H_RXBIT = 3'h4,
    H_RXACK = 3'h5,
    H_STOP = 3'h6
  } stwrs_hstate_type;

  typedef enum logic [2:0] {
    G_DEVW = 3'h0,
    G_AHI = 3'h1,
    G_ALO = 3'h2,
    G_WDATA = 3'h3,
    G_DEVR = 3'h4
  } stwrs_stage_type;

endpackage : stwrs_pkg

/* testbench/sensor_two_wire_register_slave_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_two_wire_register_slave_tb_top
  import stwrs_pkg::*;
;
  // ---------------
  // stimulus and hookup
  // ---------------
  logic mclk = 0, pixel_clock = 0, nrst = 0, pin = 0, cmd_valid = 0, cmd_sel = 0;
  logic cmd_ready, wdata_take, rd_valid, done, nack_err, wr_valid;
  logic [1:0] cmd_kind = 0;
  logic [15:0] cmd_addr = 0, wr_addr;
  logic [7:0] cmd_len = 0, wdata = 8'h1E, rd_data, wr_data;
  logic [7:0] wbuf [4] = '{8'h1E, 8'hC4, 8'h37, 8'h80};
  logic [15:0] qa [$];
  logic [7:0] qd [$], qr [$];
  int err_count = 0, cmp_count = 0, wi = 0, n;

  // two unrelated clocks
  always #25 mclk = ~mclk;
  initial
  begin
    #7;
    forever #15 pixel_clock = ~pixel_clock;
  end

  stwrs_link_if u_link ();
  stwrs_host u_stwrs_host (.mclk(mclk), .nrst(nrst), .link(u_link.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_sel(cmd_sel),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wdata(wdata), .wdata_take(wdata_take),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err));
  stwrs_device u_stwrs_device (.pixel_clock(pixel_clock), .mclk(mclk), .nrst(nrst),
    .address_select_input(pin), .link(u_link.dev), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data));
  stwrs_properties u_stwrs_properties (.mclk(mclk), .nrst(nrst), .address_select_input(pin),
    .scl(u_link.scl), .sda(u_link.sda), .sda_oe_h(u_link.sda_oe_h),
    .sda_oe_d(u_link.sda_oe_d));

  // collect reports and feed write bytes
  always @(posedge mclk)
  begin
    if (wr_valid)
    begin
      qa.push_back(wr_addr);
      qd.push_back(wr_data);
    end
    if (rd_valid)
      qr.push_back(rd_data);
    if (wdata_take)
    begin
      wi <= wi + 1;
      wdata <= wbuf[(wi + 1) % 4];
    end
  end

  // ---------------
  // tasks
  // ---------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // one host command, waits for its done pulse
  task automatic run(input logic [1:0] k, input logic s, input logic [15:0] a,
    input logic [7:0] len);
    int t;
    t = 0;
    while (cmd_ready !== 1'b1 && t < 50)
    begin
      @(posedge mclk);
      #1;
      t++;
    end
    if (t >= 50)
    begin
      err_count++;
      test_done();
    end
    @(posedge mclk);
    cmd_kind <= k;
    cmd_sel <= s;
    cmd_addr <= a;
    cmd_len <= len;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 20000)
    begin
      @(posedge mclk);
      #1;
      t++;
    end
    if (t >= 20000)
    begin
      err_count++;
      test_done();
    end
  endtask : run

  // ---------------
  // scenarios
  // ---------------
  initial
  begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    run(KIND_WRITE, 1'b0, 16'h00FE, 8'h04);
    check("reports", 16'(qa.size()), 16'h0004);
    for (int i = 0; i < 4; i++)
    begin
      check("wr_addr", qa[i], 16'h00FE + 16'(i));
      check("wr_data", 16'(qd[i]), 16'(wbuf[i]));
    end
    run(KIND_RAND_READ, 1'b0, 16'h00FE, 8'h03);
    run(KIND_CUR_READ, 1'b0, 16'h0000, 8'h01);
    check("nack_err", 16'(nack_err), 16'h0000);
    check("reads", 16'(qr.size()), 16'h0004);
    for (int i = 0; i < 4; i++)
      check("rd_data", 16'(qr[i]), 16'(wbuf[i]));
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 2; s++)
      begin
        @(posedge mclk);
        pin <= p[0];
        repeat (6) @(posedge mclk);
        n = qa.size();
        run(KIND_WRITE, s[0], 16'h0040, 8'h01);
        check("nack_err", 16'(nack_err), 16'(p != s));
        check("sel_reports", 16'(qa.size() - n), 16'(p == s));
      end
    test_done();
  end
endmodule : sensor_two_wire_register_slave_tb_top
`default_nettype wire

/* testbench/stwrs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module stwrs_properties
  import stwrs_pkg::*;
(
  input wire logic mclk, // host clock
  input wire logic nrst, // reset, active low
  input wire logic address_select_input, // address pair pin
  input wire logic scl, // clock line
  input wire logic sda, // data line
  input wire logic sda_oe_h, // host pulls data
  input wire logic sda_oe_d // device pulls data
);
  // ---------------
  // slot tracking
  // ---------------
  logic scl_q, sda_q, pb, mat, rd, nak;
  logic [3:0] bitn;
  logic [7:0] sh;
  wire logic hi = scl & scl_q;
  wire logic st = hi & sda_q & ~sda;
  wire logic [6:0] adr = address_select_input ? DEV_WR_HI[7:1] : DEV_WR_LO[7:1];

  // count bits and bytes since the last start
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      {pb, mat, rd, nak, bitn, sh} <= '0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (st)
        {pb, mat, nak, bitn} <= '0;
      else if (scl & ~scl_q)
      begin
        bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
        if (bitn < 4'h8)
          sh <= {sh[6:0], sda};
        if (bitn == 4'h9)
          pb <= 1'b1;
        if (bitn == 4'h8 && pb && rd && mat && sda) // master ack slot of a read byte
          nak <= 1'b1;
        if (bitn == 4'h8 && !pb)
        begin
          mat <= (sh[7:1] == adr);
          rd <= sh[BIT_RW];
        end
      end
    end

  // ---------------
  // properties
  // ---------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_dev_stable;
    hi |-> $stable(sda_oe_d);
  endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("device data moved, clock high");
  property p_start_host;
    st |-> sda_oe_h;
  endproperty
  a_start_host: assert property (p_start_host) else $error("start not made by host");
  property p_ack_one;
    hi && bitn == 4'h9 |-> !(sda_oe_h && sda_oe_d);
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("sender kept data in ack slot");
  property p_addr_ack;
    hi && bitn == 4'h9 && !pb |-> sda_oe_d == (sh[7:1] == adr);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  property p_wr_ack;
    hi && bitn == 4'h9 && pb && mat && !rd |-> sda_oe_d;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
  property p_rd_free;
    hi && bitn != 4'h9 && pb && mat && rd && !nak |-> !sda_oe_h;
  endproperty
  a_rd_free: assert property (p_rd_free) else $error("host drove read bit");
  property p_wr_quiet;
    hi && bitn != 4'h9 && pb && !rd |-> !sda_oe_d;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("device drove write bit");
  property p_nak_quiet;
    nak || (pb && !mat) |-> !sda_oe_d;
  endproperty
  a_nak_quiet: assert property (p_nak_quiet) else $error("device not silent");
  c_restart: cover property (pb && st);
  c_rd_ack: cover property (hi && bitn == 4'h9 && rd && mat && sda_oe_h);
  c_miss: cover property (hi && bitn == 4'h9 && !pb && !sda_oe_d);
endmodule : stwrs_properties
`default_nettype wire
